// >>> src/fbsr_top.sv
// fieldbus status word packing and reference scaling, register side
//
// Contract
// - status bits 0 to 7 carry ready, ready-to-run, enabled, fault, coast and quick stop inactive, switch-on inhibited and warning.
// - bit 8 is set while the speed error is at most a tenth of nominal speed.
// - bit 9 is set while control is remote through either external location.
// - bit 11 is set while the second external location is selected.
// - bit 12 follows the external run permit; bits 13 and 14 read zero.
// - bit 15 is set while the adapter reports a communication error.
// - the sent status word is rebuilt from the internal status every cycle.
// - references are 16-bit two's complement words.
// - two independent references, each with its own mode select.
// - each reference is scaled by its mode before reaching its output.
// - speed mode maps plus and minus 20000 to plus and minus speed scaling.
// - torque mode maps plus and minus 10000 to plus and minus 100 percent.
// - raw mode passes the reference unchanged over its full range.
// - the status word sits at 400004 in classic and 400051 in enhanced.
`timescale 1ns/1ps
`include "fbsr_defs.svh"
module fbsr_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire fbsr_pkg::fbsr_profile_e profile,
  input wire fbsr_pkg::fbsr_bus_req_s bus_req,
  output fbsr_pkg::fbsr_bus_rsp_s bus_rsp,
  input wire fbsr_pkg::fbsr_drive_s internal_status_word,
  input wire fbsr_pkg::fbsr_mode_e first_reference_mode,
  input wire fbsr_pkg::fbsr_mode_e second_reference_mode,
  input wire logic [15:0] speed_scaling,
  output logic [15:0] fieldbus_state_word,
  output logic [31:0] internal_reference_a,
  output logic [31:0] internal_reference_b,
  output logic ref_updated
);
  import fbsr_pkg::*;

  fbsr_state_s st_ff;
  fbsr_state_s nxt_st;
  logic [15:0] packed_word;
  logic [19:0] status_addr;
  fbsr_mode_e [1:0] ref_mode;
  logic [1:0][31:0] scaled;

  assign ref_mode[0] = first_reference_mode;
  assign ref_mode[1] = second_reference_mode;

  fbsr_status_packer u_packer (
    .drv(internal_status_word),
    .word(packed_word)
  );

  // one scaler per reference, each steered by its own mode
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      fbsr_ref_scaler u_scaler (
        .mode(ref_mode[gi]),
        .ref_in(st_ff.ref_raw[gi]),
        .speed_scaling(speed_scaling),
        .ref_out(scaled[gi])
      );
    end
  endgenerate

  always_comb begin
    // the status word moves with the profile
    status_addr = (profile == prof_classic) ?
      `FBSR_ADDR_SW_CLASSIC : `FBSR_ADDR_SW_ENHANCED;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.rvalid = 1'b0;
    nxt_st.rsp.wack = 1'b0;
    nxt_st.rsp.err = 1'b0;
    nxt_st.status = packed_word;
    nxt_st.int_ref = scaled;
    // pulse whenever either internal reference takes a new value
    nxt_st.ref_updated = (scaled != st_ff.int_ref);
    if (bus_req.rd) begin
      nxt_st.rsp.rvalid = 1'b1;
      // status is read from the live pack so a poll sees this cycle
      if (bus_req.addr == status_addr) begin
        nxt_st.rsp.rdata = packed_word;
      end else if (bus_req.addr == `FBSR_ADDR_REF_A) begin
        nxt_st.rsp.rdata = st_ff.ref_raw[0];
      end else if (bus_req.addr == `FBSR_ADDR_REF_B) begin
        nxt_st.rsp.rdata = st_ff.ref_raw[1];
      end else begin
        nxt_st.rsp.rdata = `FBSR_RESET_WORD;
        nxt_st.rsp.err = 1'b1;
      end
    end
    if (bus_req.wr) begin
      // raw word is kept as sent; sign handling is in the scaler
      if (bus_req.addr == `FBSR_ADDR_REF_A) begin
        nxt_st.ref_raw[0] = bus_req.wdata;
        nxt_st.rsp.wack = 1'b1;
      end else if (bus_req.addr == `FBSR_ADDR_REF_B) begin
        nxt_st.ref_raw[1] = bus_req.wdata;
        nxt_st.rsp.wack = 1'b1;
      end else begin
        // status is read only; anything else is not mapped here
        nxt_st.rsp.err = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_rsp = st_ff.rsp;
  assign fieldbus_state_word = st_ff.status;
  assign internal_reference_a = st_ff.int_ref[0];
  assign internal_reference_b = st_ff.int_ref[1];
  assign ref_updated = st_ff.ref_updated;
endmodule

// >>> src/fbsr_defs.svh
// register addresses, status bit positions and scaling constants
`ifndef FBSR_DEFS_SVH
`define FBSR_DEFS_SVH

`define FBSR_ADDR_W 20
`define FBSR_ADDR_REF_A 20'h61A82
`define FBSR_ADDR_REF_B 20'h61A83
`define FBSR_ADDR_SW_CLASSIC 20'h61A84
`define FBSR_ADDR_SW_ENHANCED 20'h61AB3

`define FBSR_BIT_RDY_ON 4'h0
`define FBSR_BIT_RDY_RUN 4'h1
`define FBSR_BIT_OP_EN 4'h2
`define FBSR_BIT_FAULT 4'h3
`define FBSR_BIT_COAST_INACT 4'h4
`define FBSR_BIT_QUICK_INACT 4'h5
`define FBSR_BIT_SWON_INHIB 4'h6
`define FBSR_BIT_WARNING 4'h7
`define FBSR_BIT_ON_TARGET 4'h8
`define FBSR_BIT_REMOTE 4'h9
`define FBSR_BIT_OVER_SUP 4'hA
`define FBSR_BIT_SECOND_LOC 4'hB
`define FBSR_BIT_RUN_PERMIT 4'hC
`define FBSR_BIT_COMM_ERR 4'hF

`define FBSR_RESET_WORD 16'h0000
`define FBSR_RESET_WIDE 32'h0000_0000

`define FBSR_SPEED_FULL 34'h0_0000_4E20
`define FBSR_TORQUE_FULL 32'h0000_2710
`define FBSR_TORQUE_PCT 32'h0000_0064
`define FBSR_TOL_MUL 21'h0000A

`endif

// >>> src/fbsr_pkg.sv
// types shared by the fieldbus status and reference scaling block
package fbsr_pkg;

  typedef enum logic [1:0] {
    mode_speed,
    mode_torque,
    mode_raw
  } fbsr_mode_e;

  typedef enum logic [1:0] {
    loc_local,
    loc_ext_a,
    loc_ext_b
  } fbsr_loc_e;

  typedef enum logic {
    prof_classic,
    prof_enhanced
  } fbsr_profile_e;

  typedef struct packed {
    logic ready_on;
    logic ready_run;
    logic op_enabled;
    logic fault_flag;
    logic coast_stop_inactive;
    logic quick_stop_inactive;
    logic switch_on_inhibited;
    logic warning;
    fbsr_loc_e location;
    logic external_run_permit;
    logic comm_error;
    logic [15:0] actual_speed;
    logic [15:0] speed_target;
    logic [15:0] nominal_speed;
    logic [15:0] supervision_limit;
  } fbsr_drive_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [19:0] addr;
    logic [15:0] wdata;
  } fbsr_bus_req_s;

  typedef struct packed {
    logic rvalid;
    logic [15:0] rdata;
    logic wack;
    logic err;
  } fbsr_bus_rsp_s;

  typedef struct packed {
    logic [1:0][15:0] ref_raw;
    logic [1:0][31:0] int_ref;
    logic [15:0] status;
    fbsr_bus_rsp_s rsp;
    logic ref_updated;
  } fbsr_state_s;

endpackage

// >>> src/fbsr_ref_scaler.sv
// converts one signed fieldbus reference into an internal reference
`timescale 1ns/1ps
`include "fbsr_defs.svh"
module fbsr_ref_scaler (
  input wire fbsr_pkg::fbsr_mode_e mode,
  input wire logic [15:0] ref_in,
  input wire logic [15:0] speed_scaling,
  output logic [31:0] ref_out
);
  import fbsr_pkg::*;

  logic signed [33:0] spd_prod;
  logic signed [33:0] spd_quot;
  logic signed [31:0] tq_prod;
  logic signed [31:0] tq_quot;
  logic signed [31:0] raw_ext;

  always_comb begin
    // two's complement input, sign extended
    raw_ext = 32'($signed(ref_in));
    spd_prod = 34'($signed(ref_in)) * 34'($signed({1'b0, speed_scaling}));
    // signed division truncates, so rounding is toward zero
    spd_quot = spd_prod / $signed(`FBSR_SPEED_FULL);
    tq_prod = raw_ext * $signed(`FBSR_TORQUE_PCT);
    tq_quot = tq_prod / $signed(`FBSR_TORQUE_FULL);
    case (mode)
      mode_speed: ref_out = spd_quot[31:0];
      mode_torque: ref_out = tq_quot;
      mode_raw: ref_out = raw_ext;
      default: ref_out = raw_ext;
    endcase
  end
endmodule

// >>> src/fbsr_status_packer.sv
// packs the drive's internal status into the fieldbus status layout
`timescale 1ns/1ps
`include "fbsr_defs.svh"
module fbsr_status_packer (
  input wire fbsr_pkg::fbsr_drive_s drv,
  output logic [15:0] word
);
  import fbsr_pkg::*;

  logic signed [16:0] err;
  logic [16:0] err_mag;
  logic [16:0] act_mag;
  logic [20:0] err_x10;

  always_comb begin
    err = 17'($signed(drv.actual_speed)) - 17'($signed(drv.speed_target));
    err_mag = err[16] ? 17'(-err) : 17'(err);
    act_mag = drv.actual_speed[15] ?
      17'(-17'($signed(drv.actual_speed))) : {1'b0, drv.actual_speed};
    // compare 10*error against nominal to avoid a divider
    err_x10 = 21'(err_mag) * `FBSR_TOL_MUL;
    word = `FBSR_RESET_WORD; // reserved bits 13 and 14 stay zero
    word[`FBSR_BIT_RDY_ON] = drv.ready_on;
    word[`FBSR_BIT_RDY_RUN] = drv.ready_run;
    word[`FBSR_BIT_OP_EN] = drv.op_enabled;
    word[`FBSR_BIT_FAULT] = drv.fault_flag;
    word[`FBSR_BIT_COAST_INACT] = drv.coast_stop_inactive;
    word[`FBSR_BIT_QUICK_INACT] = drv.quick_stop_inactive;
    word[`FBSR_BIT_SWON_INHIB] = drv.switch_on_inhibited;
    word[`FBSR_BIT_WARNING] = drv.warning;
    word[`FBSR_BIT_ON_TARGET] =
      (err_x10 <= {5'h00, drv.nominal_speed});
    word[`FBSR_BIT_REMOTE] = (drv.location != loc_local);
    word[`FBSR_BIT_OVER_SUP] =
      (act_mag >= {1'b0, drv.supervision_limit});
    word[`FBSR_BIT_SECOND_LOC] = (drv.location == loc_ext_b);
    word[`FBSR_BIT_RUN_PERMIT] = drv.external_run_permit;
    word[`FBSR_BIT_COMM_ERR] = drv.comm_error;
  end
endmodule

// >>> dv/fbsr_monitor.sv
// port checker for the fieldbus status block
`timescale 1ns/1ps
`include "fbsr_defs.svh"
module fbsr_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire fbsr_pkg::fbsr_profile_e profile,
  input wire fbsr_pkg::fbsr_bus_req_s bus_req,
  input wire fbsr_pkg::fbsr_bus_rsp_s bus_rsp,
  input wire fbsr_pkg::fbsr_drive_s internal_status_word,
  input wire logic [15:0] fieldbus_state_word
);
  import fbsr_pkg::*;
  fbsr_drive_s d;
  logic [15:0] w;
  logic [19:0] sa;
  logic [7:0] lo;
  logic on_t, over;
  int act, dif;
  assign d = internal_status_word;
  assign w = fieldbus_state_word;
  assign lo = {d.warning, d.switch_on_inhibited, d.quick_stop_inactive,
    d.coast_stop_inactive, d.fault_flag, d.op_enabled, d.ready_run,
    d.ready_on};
  assign sa = profile == prof_classic ? `FBSR_ADDR_SW_CLASSIC
    : `FBSR_ADDR_SW_ENHANCED;
  // int arithmetic keeps the speed error clear of 16-bit wrap
  always_comb begin
    act = $signed(d.actual_speed);
    dif = act - $signed(d.speed_target);
    if (act < 0) act = -act;
    if (dif < 0) dif = -dif;
    on_t = 10 * dif <= d.nominal_speed;
    over = act >= d.supervision_limit;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_LOW_BITS: assert property (
    $past(nrst) |-> w[7:0] == $past(lo)) else $error("low bits");
  AST_ON_TARGET: assert property (
    $past(nrst) |-> w[8] == $past(on_t)) else $error("on target");
  AST_REMOTE: assert property (
    $past(nrst) |-> w[9] == ($past(d.location) != loc_local))
    else $error("remote");
  AST_OVER_SUP: assert property (
    $past(nrst) |-> w[10] == $past(over)) else $error("over limit");
  AST_SECOND_LOC: assert property (
    $past(nrst) |-> w[11] == ($past(d.location) == loc_ext_b))
    else $error("second location");
  AST_RUN_PERMIT: assert property (
    $past(nrst) |-> w[14:12] == {2'h0, $past(d.external_run_permit)})
    else $error("run permit");
  AST_COMM_ERR: assert property (
    $past(nrst) |-> w[15] == $past(d.comm_error)) else $error("comm");
  AST_STATUS_READ: assert property (
    bus_req.rd && bus_req.addr == sa |=> bus_rsp.rvalid
    && !bus_rsp.err && bus_rsp.rdata == w) else $error("status read");
  AST_STATUS_RO: assert property (
    bus_req.wr && bus_req.addr == sa |=> bus_rsp.err && !bus_rsp.wack)
    else $error("status write");
  cover property (bus_req.rd && bus_req.addr == sa);
  cover property (w[8] && w[10]);
  cover property (bus_rsp.wack);
endmodule
bind fbsr_top fbsr_monitor mon_u (.mclk(mclk), .nrst(nrst),
  .profile(profile), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .internal_status_word(internal_status_word),
  .fieldbus_state_word(fieldbus_state_word));

// >>> dv/fbsr_master.sv
// fieldbus master model: one-cycle register reads and writes
`timescale 1ns/1ps
module fbsr_master (
  input wire logic mclk,
  input wire fbsr_pkg::fbsr_bus_rsp_s bus_rsp,
  output fbsr_pkg::fbsr_bus_req_s bus_req
);
  import fbsr_pkg::*;
  initial bus_req = '0;
  // released address and data flip so stale values never look valid
  task automatic xfer(input logic rd, input logic wr, input logic [19:0] a,
    input logic [15:0] wd, output fbsr_bus_rsp_s r);
    @(posedge mclk) #1;
    bus_req = '{rd, wr, a, wd};
    @(posedge mclk) #1;
    r = bus_rsp;
    bus_req = '{1'h0, 1'h0, ~a, ~wd};
  endtask
endmodule

// >>> dv/test_fbsr_top.sv
// self-checking bench for the fieldbus status and reference block
`timescale 1ns/1ps
`include "fbsr_defs.svh"
module test_fbsr_top;
  import fbsr_pkg::*;
  logic mclk = 0, nrst = 0, upd;
  fbsr_profile_e profile = prof_classic;
  fbsr_bus_req_s bus_req;
  fbsr_bus_rsp_s bus_rsp, r;
  fbsr_drive_s drv = '0;
  fbsr_mode_e mode_a = mode_speed, mode_b = mode_raw;
  logic [15:0] scal = 16'h0BB8, sw;
  logic [31:0] ref_a, ref_b;
  int n_mismatch = 0, checks = 0;
  fbsr_mode_e md[9] = '{mode_speed, mode_speed, mode_speed, mode_speed,
    mode_torque, mode_torque, mode_torque, mode_raw, mode_raw};
  logic [15:0] rv[9] = '{16'h4E20, 16'hB1E0, 16'h0007, 16'hFFF9, 16'h2710,
    16'hD8F0, 16'hFF6A, 16'h8000, 16'h7FFF};
  logic [31:0] ev[9] = '{32'h0BB8, 32'hFFFFF448, 32'h1, 32'hFFFFFFFF,
    32'h64, 32'hFFFFFF9C, 32'hFFFFFFFF, 32'hFFFF8000, 32'h7FFF};
  always #12.5 mclk = ~mclk;
  fbsr_top dut_u (.mclk(mclk), .nrst(nrst), .profile(profile),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .internal_status_word(drv),
    .first_reference_mode(mode_a), .second_reference_mode(mode_b),
    .speed_scaling(scal), .fieldbus_state_word(sw),
    .internal_reference_a(ref_a), .internal_reference_b(ref_b),
    .ref_updated(upd));
  fbsr_master master_u (.mclk(mclk), .bus_rsp(bus_rsp), .bus_req(bus_req));
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic sw_case(fbsr_drive_s v, logic [15:0] e);
    drv = v;
    @(posedge mclk) #1;
    chk("status", {16'h0, sw}, {16'h0, e});
  endtask
  task automatic t_status;
    // zero error and zero limit keep bits 8 and 10 raised here
    for (int i = 0; i < 8; i++)
      sw_case(76'h1 << (75 - i), 16'h0500 | (16'h1 << i));
    sw_case({8'h00, loc_ext_b, 2'h3, 16'hFF9C, 16'h0, 16'h03E8, 16'h0064},
      16'h9F00);
    sw_case({8'h00, loc_ext_a, 2'h0, 16'hFF9C, 16'h0, 16'h03E7, 16'h0065},
      16'h0200);
    sw_case({8'h00, loc_local, 2'h2, 16'h0064, 16'h006E, 16'h0064,
      16'h0064}, 16'h1500);
  endtask
  task automatic rd_chk(logic [19:0] a, logic [16:0] e);
    master_u.xfer(1'h1, 1'h0, a, 16'h0000, r);
    chk("read", {14'h0, r.rvalid, r.rdata, r.err}, {14'h0, 1'h1, e});
  endtask
  task automatic t_bus;
    rd_chk(`FBSR_ADDR_SW_CLASSIC, {16'h1500, 1'h0});
    rd_chk(`FBSR_ADDR_SW_ENHANCED, 17'h1);
    profile = prof_enhanced;
    rd_chk(`FBSR_ADDR_SW_ENHANCED, {16'h1500, 1'h0});
    rd_chk(`FBSR_ADDR_SW_CLASSIC, 17'h1);
    master_u.xfer(1'h0, 1'h1, `FBSR_ADDR_SW_ENHANCED, 16'hFFFF, r);
    chk("status write", {30'h0, r.wack, r.err}, 32'h1);
  endtask
  task automatic t_refs;
    for (int i = 0; i < 9; i++) begin
      mode_a = md[i];
      master_u.xfer(1'h0, 1'h1, `FBSR_ADDR_REF_A, rv[i], r);
      chk("wack", {31'h0, r.wack}, 32'h1);
      @(posedge mclk) #1;
      chk("ref a", ref_a, ev[i]);
      chk("updated", {31'h0, upd}, 32'h1);
    end
    mode_b = mode_torque;
    master_u.xfer(1'h0, 1'h1, `FBSR_ADDR_REF_B, 16'hD8F0, r);
    @(posedge mclk) #1;
    chk("ref b", ref_b, 32'hFFFFFF9C);
    chk("ref a kept", ref_a, 32'h7FFF);
    rd_chk(`FBSR_ADDR_REF_A, {16'h7FFF, 1'h0});
    rd_chk(`FBSR_ADDR_REF_B, {16'hD8F0, 1'h0});
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 nrst = 1;
    t_status;
    t_bus;
    t_refs;
    final_report;
  end
  initial begin
    #(25 * 1000);
    n_mismatch++;
    final_report;
  end
endmodule
